// ### rtl/bfsr_pkg.sv
package bfsr_pkg;

  localparam int BFSR_AW = 8;
  localparam int BFSR_DW = 8;
  localparam int BFSR_PW = 24;
  localparam int BFSR_OW = 16;
  localparam int BFSR_RW_NUM = 7;

  localparam logic [7:0] BFSR_OFS_FIFO_CONTROL = 8'h14;
  localparam logic [7:0] BFSR_OFS_REF_LOW = 8'h15;
  localparam logic [7:0] BFSR_OFS_REF_MID = 8'h16;
  localparam logic [7:0] BFSR_OFS_REF_HIGH = 8'h17;
  localparam logic [7:0] BFSR_OFS_OFFSET_LOW = 8'h18;
  localparam logic [7:0] BFSR_OFS_OFFSET_HIGH = 8'h19;
  localparam logic [7:0] BFSR_OFS_POWER_MODE = 8'h1a;
  localparam logic [7:0] BFSR_OFS_EVENT_SOURCE = 8'h25;
  localparam logic [7:0] BFSR_OFS_QUEUE_STATUS = 8'h26;
  localparam logic [7:0] BFSR_OFS_SAMPLE_STATUS = 8'h27;
  localparam logic [7:0] BFSR_OFS_RESULT_LOW = 8'h28;
  localparam logic [7:0] BFSR_OFS_RESULT_MID = 8'h29;
  localparam logic [7:0] BFSR_OFS_RESULT_HIGH = 8'h2a;

  localparam logic [7:0] BFSR_RST_BYTE = 8'h00;
  localparam logic [7:0] BFSR_POWER_MODE_MASK = 8'h03;

  localparam int BFSR_MODE_LSB = 5;
  localparam int BFSR_THR_LSB = 0;
  localparam int BFSR_LC_BIT = 0;
  localparam int BFSR_SRC_BOOT_BIT = 7;
  localparam int BFSR_SRC_ANY_BIT = 2;
  localparam int BFSR_SRC_BELOW_BIT = 1;
  localparam int BFSR_SRC_ABOVE_BIT = 0;
  localparam int BFSR_QST_THR_BIT = 7;
  localparam int BFSR_QST_OVW_BIT = 6;
  localparam int BFSR_SMP_T_LOST_BIT = 5;
  localparam int BFSR_SMP_P_LOST_BIT = 4;
  localparam int BFSR_SMP_T_RDY_BIT = 1;
  localparam int BFSR_SMP_P_RDY_BIT = 0;

  localparam logic [2:0] BFSR_MODE_BYPASS = 3'h0;
  localparam logic [2:0] BFSR_MODE_FIFO = 3'h1;
  localparam logic [2:0] BFSR_MODE_STREAM = 3'h2;
  localparam logic [2:0] BFSR_MODE_STREAM_FIFO = 3'h3;
  localparam logic [2:0] BFSR_MODE_BYPASS_STREAM = 3'h4;
  localparam logic [2:0] BFSR_MODE_RESERVED = 3'h5;
  localparam logic [2:0] BFSR_MODE_DYN_STREAM = 3'h6;
  localparam logic [2:0] BFSR_MODE_BYPASS_FIFO = 3'h7;
  localparam logic [2:0] BFSR_RST_MODE = BFSR_MODE_BYPASS;

  typedef struct packed {
    logic press_new;
    logic temp_new;
    logic [BFSR_PW-1:0] pressure;
  } bfsr_sample_s;

  typedef struct packed {
    logic boot_running;
    logic event_any;
    logic pressure_below_event;
    logic pressure_above_event;
  } bfsr_sense_s;

  typedef struct packed {
    logic differential_enable;
    logic automatic_zeroing;
    logic automatic_reference;
    logic block_data_update;
  } bfsr_mode_s;

endpackage

// ### rtl/bfsr_press_out.sv
// pressure result stage: offset correction and block update hold
`timescale 1ns/100ps
module bfsr_press_out
  import bfsr_pkg::*;
#(
  parameter int PW = BFSR_PW,
  parameter int OW = BFSR_OW
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [PW-1:0] i_raw,
  input wire logic [OW-1:0] i_offset,
  input wire logic i_apply_offset,
  input wire logic i_block_data_update,
  input wire logic i_high_read,
  output logic [PW-1:0] o_value
);

  logic [PW-1:0] value_q;
  logic [PW-1:0] pend_q;
  logic pend_valid_q;
  logic frozen_q;
  logic [PW-1:0] offset_ext;
  logic [PW-1:0] corrected;
  logic take_new;
  logic take_pend;

  assign offset_ext = {{(PW-OW){i_offset[OW-1]}}, i_offset};
  // measured minus calibration offset, two's complement wrap
  assign corrected = i_apply_offset ? i_raw - offset_ext : i_raw;
  assign take_new = i_load && !(frozen_q && !i_high_read);
  assign take_pend = !i_load && pend_valid_q && frozen_q && i_high_read;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      value_q <= '0;
      pend_q <= '0;
      pend_valid_q <= 1'b0;
      frozen_q <= 1'b0;
    end else begin
      if (take_new) begin
        value_q <= corrected;
      end else if (take_pend) begin
        value_q <= pend_q;
      end
      if (i_load && !take_new) begin
        pend_q <= corrected;
        pend_valid_q <= 1'b1;
      end else if (take_pend || take_new) begin
        pend_valid_q <= 1'b0;
      end
      if ((take_new || take_pend) && i_block_data_update) begin
        frozen_q <= 1'b1;
      end else if (i_high_read || !i_block_data_update) begin
        frozen_q <= 1'b0;
      end
    end
  end

  assign o_value = value_q;

endmodule

// ### rtl/bfsr_regs.sv
// register bank: queue control, reference, offset, status, result
`timescale 1ns/100ps
module bfsr_regs
  import bfsr_pkg::*;
#(
  parameter int FILL_W = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [BFSR_AW-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [BFSR_DW-1:0] i_reg_wdata,
  output logic [BFSR_DW-1:0] o_reg_rdata,
  input wire logic i_rate_tick,
  input wire bfsr_sample_s i_sample,
  input wire logic i_temp_taken,
  input wire bfsr_sense_s i_sense,
  input wire bfsr_mode_s i_mode,
  input wire logic [FILL_W-1:0] i_queue_fill_count,
  input wire logic i_queue_overwritten,
  output logic [2:0] o_queue_mode,
  output logic [4:0] o_queue_threshold_level,
  output logic [BFSR_PW-1:0] o_reference_pressure_bits,
  output logic o_reference_active,
  output logic [BFSR_OW-1:0] o_calibration_offset_bits,
  output logic o_low_current_select,
  output logic [BFSR_PW-1:0] o_pressure_result_bits
);

  // writable bytes 14h..1Ah held as one array, index = offset - 14h
  logic [BFSR_DW-1:0] rw_q [BFSR_RW_NUM];
  logic [BFSR_DW-1:0] rw_wdata [BFSR_RW_NUM];
  logic [BFSR_RW_NUM-1:0] rw_hit;

  logic [BFSR_DW-1:0] rdata_q;
  logic ref_active_q;
  logic press_rdy_q;
  logic temp_rdy_q;
  logic press_ovr_q;
  logic temp_ovr_q;
  logic [BFSR_DW-1:0] status_q;

  logic [2:0] mode_wr;
  logic mode_wr_ok;
  logic [2:0] cur_mode;
  logic [4:0] cur_threshold;
  logic [BFSR_PW-1:0] ref_bits;
  logic [BFSR_OW-1:0] offset_bits;
  logic [BFSR_PW-1:0] result_bits;
  logic apply_offset;
  logic high_read;
  logic press_clear;
  logic temp_clear;
  logic thr_flag;
  logic ovw_flag;
  logic [BFSR_DW-1:0] src_byte;
  logic [BFSR_DW-1:0] qst_byte;
  logic [BFSR_DW-1:0] live_status;
  logic [BFSR_DW-1:0] rd_mux;
  logic [5:0] fill6;

  // queue mode and threshold fields
  assign cur_mode = rw_q[0][BFSR_MODE_LSB +: 3];
  assign cur_threshold = rw_q[0][BFSR_THR_LSB +: 5];
  assign mode_wr = i_reg_wdata[BFSR_MODE_LSB +: 3];
  // the reserved code never reaches the queue; old mode is kept
  assign mode_wr_ok = (mode_wr != BFSR_MODE_RESERVED);

  assign ref_bits = {rw_q[3], rw_q[2], rw_q[1]};
  assign offset_bits = {rw_q[5], rw_q[4]};

  // write data shaping per writable byte
  genvar k;
  generate
    for (k = 0; k < BFSR_RW_NUM; k++) begin : g_rw
      assign rw_hit[k] = i_reg_wr &&
        (i_reg_addr == BFSR_OFS_FIFO_CONTROL + 8'(k));
      if (k == 0) begin : g_ctl
        assign rw_wdata[k] = {mode_wr_ok ? mode_wr : cur_mode,
                              i_reg_wdata[BFSR_THR_LSB +: 5]};
      end else if (k == BFSR_RW_NUM - 1) begin : g_pwr
        // only the select bit and the reserved bit are stored
        assign rw_wdata[k] = i_reg_wdata & BFSR_POWER_MODE_MASK;
      end else begin : g_plain
        assign rw_wdata[k] = i_reg_wdata;
      end
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          rw_q[k] <= BFSR_RST_BYTE;
        end else if (rw_hit[k]) begin
          rw_q[k] <= rw_wdata[k];
        end
      end
    end
  endgenerate

  // reads of the result high byte release the block update hold
  assign high_read = i_reg_rd && (i_reg_addr == BFSR_OFS_RESULT_HIGH);
  assign press_clear = high_read;
  assign temp_clear = i_temp_taken;

  // offset correction only with every relative function off
  assign apply_offset = !i_mode.differential_enable &&
                        !i_mode.automatic_zeroing &&
                        !i_mode.automatic_reference;

  bfsr_press_out #(
    .PW(BFSR_PW),
    .OW(BFSR_OW)
  ) u_press_out (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_load(i_sample.press_new),
    .i_raw(i_sample.pressure),
    .i_offset(offset_bits),
    .i_apply_offset(apply_offset),
    .i_block_data_update(i_mode.block_data_update),
    .i_high_read(high_read),
    .o_value(result_bits)
  );

  // ready and overrun flags; a new sample wins over a clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      press_rdy_q <= 1'b0;
      press_ovr_q <= 1'b0;
    end else begin
      if (i_sample.press_new) begin
        press_rdy_q <= 1'b1;
        press_ovr_q <= press_rdy_q || press_ovr_q;
      end else if (press_clear) begin
        press_rdy_q <= 1'b0;
        press_ovr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      temp_rdy_q <= 1'b0;
      temp_ovr_q <= 1'b0;
    end else begin
      if (i_sample.temp_new) begin
        temp_rdy_q <= 1'b1;
        temp_ovr_q <= temp_rdy_q || temp_ovr_q;
      end else if (temp_clear) begin
        temp_rdy_q <= 1'b0;
        temp_ovr_q <= 1'b0;
      end
    end
  end

  assign live_status = {2'b00,
                        temp_ovr_q,
                        press_ovr_q,
                        2'b00,
                        temp_rdy_q,
                        press_rdy_q};

  // visible data status follows the live flags once per rate period
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      status_q <= BFSR_RST_BYTE;
    end else if (i_rate_tick) begin
      status_q <= live_status;
    end
  end

  // queue status from the fill level and overwrite indication
  assign fill6 = 6'(i_queue_fill_count);
  assign thr_flag = (fill6 >= {1'b0, cur_threshold});
  assign ovw_flag = i_queue_overwritten && (fill6 == 6'h20);
  assign qst_byte = {thr_flag, ovw_flag, fill6};

  assign src_byte = {i_sense.boot_running,
                     4'h0,
                     i_sense.event_any,
                     i_sense.pressure_below_event,
                     i_sense.pressure_above_event};

  // read multiplexer; unmapped offsets read zero
  assign rd_mux =
    (i_reg_addr == BFSR_OFS_FIFO_CONTROL) ? rw_q[0] :
    (i_reg_addr == BFSR_OFS_REF_LOW) ? rw_q[1] :
    (i_reg_addr == BFSR_OFS_REF_MID) ? rw_q[2] :
    (i_reg_addr == BFSR_OFS_REF_HIGH) ? rw_q[3] :
    (i_reg_addr == BFSR_OFS_OFFSET_LOW) ? rw_q[4] :
    (i_reg_addr == BFSR_OFS_OFFSET_HIGH) ? rw_q[5] :
    (i_reg_addr == BFSR_OFS_POWER_MODE) ? rw_q[6] :
    (i_reg_addr == BFSR_OFS_EVENT_SOURCE) ? src_byte :
    (i_reg_addr == BFSR_OFS_QUEUE_STATUS) ? qst_byte :
    (i_reg_addr == BFSR_OFS_SAMPLE_STATUS) ? status_q :
    (i_reg_addr == BFSR_OFS_RESULT_LOW) ? result_bits[7:0] :
    (i_reg_addr == BFSR_OFS_RESULT_MID) ? result_bits[15:8] :
    (i_reg_addr == BFSR_OFS_RESULT_HIGH) ? result_bits[23:16] :
    BFSR_RST_BYTE;

  // read data holds until the next read strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= BFSR_RST_BYTE;
    end else if (i_reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // writes to status and result offsets match no writable byte
  // and so change nothing
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ref_active_q <= 1'b0;
    end else begin
      ref_active_q <= i_mode.automatic_zeroing ||
                      i_mode.automatic_reference;
    end
  end

  // holds by construction: rw_hit decodes writable bytes only

  assign o_reg_rdata = rdata_q;
  assign o_queue_mode = cur_mode;
  assign o_queue_threshold_level = cur_threshold;
  assign o_reference_pressure_bits = ref_bits;
  assign o_reference_active = ref_active_q;
  assign o_calibration_offset_bits = offset_bits;
  assign o_low_current_select = rw_q[6][BFSR_LC_BIT];
  assign o_pressure_result_bits = result_bits;

endmodule

// ### tb/bfsr_regs_chk.sv
// assertion checker for the register bank ports
`timescale 1ns/100ps
module bfsr_regs_chk
  import bfsr_pkg::*;
#(
  parameter int FILL_W = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [BFSR_AW-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [BFSR_DW-1:0] i_reg_wdata,
  input wire logic [BFSR_DW-1:0] o_reg_rdata,
  input wire logic i_rate_tick,
  input wire bfsr_sample_s i_sample,
  input wire logic i_temp_taken,
  input wire bfsr_sense_s i_sense,
  input wire bfsr_mode_s i_mode,
  input wire logic [FILL_W-1:0] i_queue_fill_count,
  input wire logic i_queue_overwritten,
  input wire logic [2:0] o_queue_mode,
  input wire logic [4:0] o_queue_threshold_level,
  input wire logic [BFSR_PW-1:0] o_reference_pressure_bits,
  input wire logic o_reference_active,
  input wire logic [BFSR_OW-1:0] o_calibration_offset_bits,
  input wire logic o_low_current_select,
  input wire logic [BFSR_PW-1:0] o_pressure_result_bits
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic wfc = i_reg_wr && i_reg_addr == BFSR_OFS_FIFO_CONTROL;
  wire logic ref_on = i_mode.automatic_zeroing || i_mode.automatic_reference;
  wire logic plain = !ref_on && !i_mode.differential_enable;
  wire logic [23:0] ofs_x = {{8{o_calibration_offset_bits[15]}},
    o_calibration_offset_bits};
  wire logic [7:0] src_v = {i_sense.boot_running, 4'h0, i_sense.event_any,
    i_sense.pressure_below_event, i_sense.pressure_above_event};
  wire logic [7:0] qst_v = {
    i_queue_fill_count >= FILL_W'(o_queue_threshold_level),
    i_queue_overwritten && i_queue_fill_count == FILL_W'(32),
    6'(i_queue_fill_count)};

  chk_mode_write: assert property (
    wfc && i_reg_wdata[7:5] != BFSR_MODE_RESERVED
    |=> o_queue_mode == $past(i_reg_wdata[7:5])) else $error("mode lost");
  chk_mode_reserved: assert property (
    wfc && i_reg_wdata[7:5] == BFSR_MODE_RESERVED |=> $stable(o_queue_mode))
    else $error("reserved mode taken");
  chk_thr_write: assert property (
    wfc |=> o_queue_threshold_level == $past(i_reg_wdata[4:0]))
    else $error("threshold lost");
  chk_ref_high: assert property (
    i_reg_wr && i_reg_addr == BFSR_OFS_REF_HIGH
    |=> o_reference_pressure_bits[23:16] == $past(i_reg_wdata))
    else $error("reference high byte lost");
  chk_ref_active: assert property (
    1'b1 |=> o_reference_active == $past(ref_on))
    else $error("reference use wrong");
  chk_ofs_low: assert property (
    i_reg_wr && i_reg_addr == BFSR_OFS_OFFSET_LOW
    |=> o_calibration_offset_bits[7:0] == $past(i_reg_wdata))
    else $error("offset low byte lost");
  chk_lc_write: assert property (
    i_reg_wr && i_reg_addr == BFSR_OFS_POWER_MODE
    |=> o_low_current_select == $past(i_reg_wdata[0]))
    else $error("low current bit lost");
  chk_src_read: assert property (
    i_reg_rd && i_reg_addr == BFSR_OFS_EVENT_SOURCE
    |=> o_reg_rdata == $past(src_v)) else $error("source read wrong");
  chk_queue_read: assert property (
    i_reg_rd && i_reg_addr == BFSR_OFS_QUEUE_STATUS
    |=> o_reg_rdata == $past(qst_v)) else $error("queue status wrong");
  chk_result_sub: assert property (
    i_sample.press_new && plain && !i_mode.block_data_update
    |=> o_pressure_result_bits == $past(i_sample.pressure) - $past(ofs_x))
    else $error("result not corrected");
  chk_ro_write: assert property (
    i_reg_wr && i_reg_addr inside {[8'h25:8'h2a]} && !i_sample.press_new
    |=> $stable(o_pressure_result_bits)) else $error("result written");

  cover property (wfc && i_reg_wdata[7:5] == BFSR_MODE_RESERVED);
  cover property (i_sample.press_new && i_mode.block_data_update);
  cover property (i_reg_rd && i_queue_overwritten);
endmodule

bind bfsr_regs bfsr_regs_chk #(.FILL_W(FILL_W)) chk_u (.*);

// ### tb/bfsr_host.sv
// host model driving the register port of the bank
`timescale 1ns/100ps
module bfsr_host
  import bfsr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [BFSR_DW-1:0] i_reg_rdata,
  output logic [BFSR_AW-1:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [BFSR_DW-1:0] o_reg_wdata
);
  initial begin
    o_reg_addr = 8'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // idle address and data are scrambled so stale values are never trusted
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    @(negedge i_ref_clk);
    d = i_reg_rdata;
  endtask
  // called only while no sampling runs; high bits zero, bit 1 kept
  task automatic set_low_current(input logic lc);
    logic [7:0] v;
    rd_reg(BFSR_OFS_POWER_MODE, v);
    wr_reg(BFSR_OFS_POWER_MODE, {6'h00, v[1], lc});
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the register bank
`timescale 1ns/100ps
module tb_top;
  import bfsr_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic i_reg_wr, i_reg_rd, o_reference_active, o_low_current_select;
  logic i_rate_tick = 1'b0;
  logic i_temp_taken = 1'b0;
  bfsr_sample_s i_sample = '0;
  bfsr_sense_s i_sense = '0;
  bfsr_mode_s i_mode = '0;
  logic [5:0] i_queue_fill_count = 6'h00;
  logic i_queue_overwritten = 1'b0;
  logic [2:0] o_queue_mode, m_exp;
  logic [4:0] o_queue_threshold_level;
  logic [23:0] o_reference_pressure_bits, o_pressure_result_bits, p, ex;
  logic [15:0] o_calibration_offset_bits, o;
  logic [7:0] t;
  int error_cnt = 0;
  int cmp_count = 0;
  int fl[7] = '{0, 9, 10, 11, 31, 32, 32};
  always #2.5 i_ref_clk = ~i_ref_clk;
  bfsr_regs dut_u (.*);
  bfsr_host host_u (
    .i_ref_clk(i_ref_clk),
    .i_reg_rdata(o_reg_rdata),
    .o_reg_addr(i_reg_addr),
    .o_reg_wr(i_reg_wr),
    .o_reg_rd(i_reg_rd),
    .o_reg_wdata(i_reg_wdata)
  );
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd_reg(a, d);
    check(24'(d), 24'(e));
  endtask
  task automatic sample(input logic [23:0] v, input logic pn, input logic tn);
    @(posedge i_ref_clk);
    i_sample <= '{pn, tn, v};
    @(posedge i_ref_clk);
    i_sample <= '{1'b0, 1'b0, ~v};
  endtask
  task automatic pulse_tick;
    @(posedge i_ref_clk);
    i_rate_tick <= 1'b1;
    @(posedge i_ref_clk);
    i_rate_tick <= 1'b0;
  endtask
  function automatic logic [23:0] exp_res(input logic [23:0] raw);
    return raw - {{8{o[15]}}, o};
  endfunction
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(1));
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd_chk(BFSR_OFS_FIFO_CONTROL, 8'h00);
    m_exp = BFSR_RST_MODE;
    for (int m = 0; m < 8; m++) begin
      t = 8'($urandom);
      host_u.wr_reg(BFSR_OFS_FIFO_CONTROL, {m[2:0], t[4:0]});
      if (m[2:0] != BFSR_MODE_RESERVED) begin
        m_exp = m[2:0];
      end
      @(negedge i_ref_clk);
      check(24'(o_queue_mode), 24'(m_exp));
      rd_chk(BFSR_OFS_FIFO_CONTROL, {m_exp, t[4:0]});
    end
    check(24'(o_queue_threshold_level), 24'(t[4:0]));
    $display("test queue control done");
    p = 24'($urandom);
    o = 16'($urandom) | 16'h8000;
    for (int i = 0; i < 3; i++) begin
      host_u.wr_reg(BFSR_OFS_REF_LOW + 8'(i), p[8*i +: 8]);
    end
    host_u.wr_reg(BFSR_OFS_OFFSET_LOW, o[7:0]);
    host_u.wr_reg(BFSR_OFS_OFFSET_HIGH, o[15:8]);
    @(negedge i_ref_clk);
    check(o_reference_pressure_bits, p);
    check(24'(o_calibration_offset_bits), 24'(o));
    rd_chk(BFSR_OFS_REF_MID, p[15:8]);
    rd_chk(BFSR_OFS_OFFSET_HIGH, o[15:8]);
    @(posedge i_ref_clk);
    i_mode.automatic_zeroing <= 1'b1;
    repeat (2) @(negedge i_ref_clk);
    check(24'(o_reference_active), 24'(1'b1));
    @(posedge i_ref_clk);
    i_mode.automatic_zeroing <= 1'b0;
    repeat (2) @(negedge i_ref_clk);
    check(24'(o_reference_active), 24'(1'b0));
    host_u.set_low_current(1'b1);
    @(negedge i_ref_clk);
    check(24'(o_low_current_select), 24'(1'b1));
    rd_chk(BFSR_OFS_POWER_MODE, 8'h01);
    host_u.set_low_current(1'b0);
    $display("test reference and power mode done");
    for (int i = 0; i < 4; i++) begin
      t = 8'($urandom);
      @(posedge i_ref_clk);
      i_sense <= t[3:0];
      rd_chk(BFSR_OFS_EVENT_SOURCE, {t[3], 4'h0, t[2:0]});
    end
    host_u.wr_reg(BFSR_OFS_FIFO_CONTROL, 8'h0a);
    foreach (fl[i]) begin
      @(posedge i_ref_clk);
      i_queue_fill_count <= 6'(fl[i]);
      i_queue_overwritten <= i[0];
      t = {fl[i] >= 10, i[0] && fl[i] == 32, 6'(fl[i])};
      rd_chk(BFSR_OFS_QUEUE_STATUS, t);
    end
    $display("test source and queue status done");
    p = 24'($urandom);
    sample(p, 1'b1, 1'b0);
    @(negedge i_ref_clk);
    check(o_pressure_result_bits, exp_res(p));
    rd_chk(BFSR_OFS_SAMPLE_STATUS, 8'h00);
    p = 24'($urandom);
    sample(p, 1'b1, 1'b0);
    pulse_tick();
    rd_chk(BFSR_OFS_SAMPLE_STATUS, 8'h11);
    ex = exp_res(p);
    for (int i = 0; i < 3; i++) begin
      rd_chk(BFSR_OFS_RESULT_LOW + 8'(i), ex[8*i +: 8]);
    end
    pulse_tick();
    rd_chk(BFSR_OFS_SAMPLE_STATUS, 8'h00);
    sample(p, 1'b0, 1'b1);
    sample(p, 1'b0, 1'b1);
    pulse_tick();
    rd_chk(BFSR_OFS_SAMPLE_STATUS, 8'h22);
    @(posedge i_ref_clk);
    i_temp_taken <= 1'b1;
    @(posedge i_ref_clk);
    i_temp_taken <= 1'b0;
    pulse_tick();
    rd_chk(BFSR_OFS_SAMPLE_STATUS, 8'h00);
    $display("test sample flags done");
    @(posedge i_ref_clk);
    i_mode.block_data_update <= 1'b1;
    sample(p, 1'b1, 1'b0);
    sample(~p, 1'b1, 1'b0);
    repeat (2) @(negedge i_ref_clk);
    check(o_pressure_result_bits, ex);
    rd_chk(BFSR_OFS_RESULT_HIGH, ex[23:16]);
    repeat (2) @(negedge i_ref_clk);
    ex = exp_res(~p);
    check(o_pressure_result_bits, ex);
    host_u.wr_reg(BFSR_OFS_RESULT_LOW, ~ex[7:0]);
    rd_chk(BFSR_OFS_RESULT_LOW, ex[7:0]);
    host_u.wr_reg(8'h40, 8'hff);
    rd_chk(8'h40, 8'h00);
    rd_chk(BFSR_OFS_FIFO_CONTROL, 8'h0a);
    $display("test block update and writes done");
    stop_test();
  end
endmodule
